// *** slfm_ctrl.sv ***
// supply-loss and fail-mode control of a multi-channel high-side switch
// assumes synchronous inputs on i_mclk; supplies come as comparator levels
// Functional notes
// [RULE1] clock pin reports wake while reset low
// [RULE2] awake and reset low: drive pin high
// [RULE3] sleep or reset-woken: pin stays input
// [RULE4] functional only when wake asserted
// [RULE5] both supplies lost: outputs off, clear all
// [RULE6] battery lost, logic present: keep registers
// [RULE7] battery lost: channels off, external follows spi
// [RULE8] battery lost: no wake report on pin
// [RULE9] logic supply lost: treat as watchdog timeout
// [RULE10] no logic supply: no register readback
// [RULE11] ground lost: channels off, external pulled up
// [RULE12] normal mode: channels from pwm
// [RULE13] report eight fault classes over spi
// [RULE14] fail-mode request high enters fail mode
// [RULE15] fail mode: channels follow direct inputs
// [RULE16] direct control only in fail mode
// [RULE17] request level readable in status seven
// [RULE18] undriven request reads low
// [RULE19] spi communication error enters fail mode
// [RULE20] request and inputs deglitched 200 us
// [RULE21] request low, no fault: normal mode
`timescale 1ns/1ps
`include "slfm_params.svh"
module slfm_ctrl #(
    parameter int NUM_CH  = `SLFM_NUM_CH,
    parameter int NUM_IN  = `SLFM_NUM_IN,
    parameter int DGL_CYC = `SLFM_DGL_CYC
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_wake,
    input  wire logic                          i_reset_input_low_n,
    input  wire logic                          i_woken_by_reset,
    input  wire slfm_pkg::slfm_supply_t        i_supply,
    input  wire logic                          i_fail_req,
    input  wire logic [NUM_IN-1:0]             i_direct_channel_inputs,
    input  wire logic [NUM_CH-1:0]             i_pwm_ch,
    input  wire logic                          i_spi_ext_cfg,
    input  wire slfm_pkg::slfm_spi_err_t       i_spi_err,
    input  wire logic [`SLFM_FAULT_W-1:0]      i_fault_evt,
    input  wire logic                          i_fault_clr,
    input  wire logic                          i_clk_pin_in,
    output logic                               o_clk_pin_out,
    output logic                               o_clk_pin_oe_n,
    output logic                               o_clk_pin_sample,
    output logic [NUM_CH-1:0]                  o_power_channel_outputs,
    output logic                               o_external_switch_drive,
    output logic                               o_ext_drive_pullup,
    output slfm_pkg::slfm_mode_t               o_mode,
    output logic [`SLFM_FAULT_W-1:0]           o_fault_flags,
    output logic [7:0]                         o_stat7,
    output logic                               o_readback_en
);
    // counter compare width, wide enough for the 200 us count
    localparam logic [`SLFM_CNT_W-1:0] DGL_LIM = `SLFM_CNT_W'(DGL_CYC - 1);

    slfm_pkg::slfm_mode_t mode_ff;            // current operating mode
    slfm_pkg::slfm_mode_t nxt_mode;           // next mode
    logic                 req_dgl_ff;         // deglitched fail request
    logic [`SLFM_CNT_W-1:0] req_cnt_ff;       // request deglitch counter
    logic [NUM_IN-1:0]    in_dgl_ff;          // deglitched direct inputs
    logic [`SLFM_CNT_W-1:0] in_cnt_ff [NUM_IN]; // per-input counters
    logic                 spi_failure_flag_ff;            // latched spi failure flag
    logic [`SLFM_FAULT_W-1:0] fault_ff;       // sticky fault records
    logic                 ext_cfg_ff;         // held external drive config
    logic                 spi_fault;          // any spi communication fault
    logic                 por_clear;          // both supplies gone

    // symmetric deglitch step; returns new counter value
    function automatic logic [`SLFM_CNT_W-1:0] dgl_step(
        input logic                     raw,
        input logic                     cur,
        input logic [`SLFM_CNT_W-1:0]   cnt
    );
        dgl_step = (raw == cur) ? '0 : cnt + `SLFM_CNT_W'(1);
    endfunction

    assign por_clear = !i_supply.bat_ok && !i_supply.vcc_ok;  // [RULE5]
    // vcc loss counts as watchdog timeout since spi is dead
    assign spi_fault = i_spi_err.wd_toggle_err || i_spi_err.wd_timeout
                    || i_spi_err.len_err || !i_supply.vcc_ok;   // [RULE9] [RULE19]

    // request deglitcher; undriven pin arrives low via external pull-down
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            req_cnt_ff <= '0;
            req_dgl_ff <= 1'b0;                 // [RULE18]
        end
        else if (req_cnt_ff == DGL_LIM)
        begin
            req_cnt_ff <= '0;
            req_dgl_ff <= i_fail_req;           // [RULE20]
        end
        else
        begin
            req_cnt_ff <= dgl_step(i_fail_req, req_dgl_ff, req_cnt_ff);
        end
    end

    // direct input deglitchers, one process so each vector has one driver
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            in_dgl_ff <= '0;
            for (int k = 0; k < NUM_IN; k++)
                in_cnt_ff[k] <= '0;
        end
        else
        begin
            for (int k = 0; k < NUM_IN; k++)
            begin
                if (in_cnt_ff[k] == DGL_LIM)
                begin
                    in_cnt_ff[k] <= '0;
                    in_dgl_ff[k] <= i_direct_channel_inputs[k];  // [RULE20]
                end
                else
                    in_cnt_ff[k] <= dgl_step(i_direct_channel_inputs[k], in_dgl_ff[k],
                                             in_cnt_ff[k]);
            end
        end
    end

    // mode selection; loss of both supplies beats wake, fail beats normal
    always_comb
    begin
        if (por_clear)
            nxt_mode = slfm_pkg::SLFM_POWER_OFF;               // [RULE5]
        else if (!i_wake)
            nxt_mode = slfm_pkg::SLFM_SLEEP;                   // [RULE4]
        else if (req_dgl_ff || spi_fault)
            nxt_mode = slfm_pkg::SLFM_FAIL;                    // [RULE14] [RULE19]
        else
            nxt_mode = slfm_pkg::SLFM_NORMAL;                  // [RULE21]
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mode_ff <= slfm_pkg::SLFM_POWER_OFF;
        else
            mode_ff <= nxt_mode;
    end

    // spi failure flag: held in fail mode, cleared on fail-to-normal
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            spi_failure_flag_ff <= 1'b0;
        else if (por_clear)
            spi_failure_flag_ff <= 1'b0;                                   // [RULE5]
        else if (spi_fault)
            spi_failure_flag_ff <= 1'b1;                                   // set wins over the fail-to-normal clear
        else if (mode_ff == slfm_pkg::SLFM_FAIL && nxt_mode == slfm_pkg::SLFM_NORMAL)
            spi_failure_flag_ff <= 1'b0;
    end

    // sticky fault records; battery loss alone keeps them
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fault_ff <= '0;
        else if (por_clear)
            fault_ff <= '0;                                    // [RULE5]
        else
            fault_ff <= i_fault_evt | (i_fault_clr ? '0 : fault_ff);  // [RULE6] [RULE13]
    end

    // external drive config kept through battery loss
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ext_cfg_ff <= 1'b0;
        else if (por_clear)
            ext_cfg_ff <= 1'b0;
        else
            ext_cfg_ff <= i_spi_ext_cfg;                       // [RULE6]
    end

    // channel outputs: fail uses direct inputs, normal uses pwm
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_power_channel_outputs <= '0;
        else if (!i_supply.bat_ok || !i_supply.gnd_ok || por_clear)
            o_power_channel_outputs <= '0;                     // [RULE7] [RULE11]
        else
        begin
            case (nxt_mode)
                slfm_pkg::SLFM_NORMAL:
                    o_power_channel_outputs <= i_pwm_ch;       // [RULE12]
                slfm_pkg::SLFM_FAIL:
                    // channels without a direct input stay off
                    o_power_channel_outputs <= NUM_CH'(in_dgl_ff);  // [RULE15] [RULE16]
                default:
                    o_power_channel_outputs <= '0;
            endcase
        end
    end

    // external drive: normal mode only, follows held spi config
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_external_switch_drive <= 1'b0;
            o_ext_drive_pullup      <= 1'b0;
        end
        else
        begin
            o_ext_drive_pullup      <= !i_supply.gnd_ok;       // [RULE11]
            o_external_switch_drive <= i_supply.gnd_ok && i_supply.vcc_ok
                && nxt_mode == slfm_pkg::SLFM_NORMAL && ext_cfg_ff;  // [RULE7]
        end
    end

    // wake report on clock pin while reset input low
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_clk_pin_out  <= 1'b0;
            o_clk_pin_oe_n <= 1'b1;
        end
        else if (!i_reset_input_low_n && i_wake && !i_woken_by_reset
                 && i_supply.bat_ok && i_supply.vcc_ok)
        begin
            o_clk_pin_out  <= 1'b1;                            // [RULE1] [RULE2] [RULE8]
            o_clk_pin_oe_n <= 1'b0;
        end
        else
        begin
            o_clk_pin_out  <= 1'b0;                            // [RULE3]
            o_clk_pin_oe_n <= 1'b1;
        end
    end

    // pass clock input onward only when not driving it
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_clk_pin_sample <= 1'b0;
        else
            o_clk_pin_sample <= o_clk_pin_oe_n ? i_clk_pin_in : 1'b0;
    end

    // status seven and readback gate
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_stat7       <= '0;
            o_readback_en <= 1'b0;
        end
        else
        begin
            o_stat7 <= '0;
            o_stat7[`SLFM_STAT7_LIMP_BIT] <= i_fail_req;       // [RULE17]
            o_stat7[`SLFM_STAT7_SPI_FAILURE_FLAG_BIT] <= spi_failure_flag_ff;
            o_readback_en <= i_supply.vcc_ok;                  // [RULE10]
        end
    end

    assign o_mode        = mode_ff;
    assign o_fault_flags = fault_ff;

    // checks
    property p_fail_on_req;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (req_dgl_ff && i_wake && !por_clear) |=> (mode_ff == slfm_pkg::SLFM_FAIL);
    endproperty
    a_fail_on_req: assert property (p_fail_on_req) else $error("no fail on request"); // [RULE14]

    property p_bat_loss_off;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_supply.bat_ok |=> (o_power_channel_outputs == '0);
    endproperty
    a_bat_loss_off: assert property (p_bat_loss_off) else $error("channels on at bat loss"); // [RULE7]

    property p_gnd_loss;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_supply.gnd_ok |=> o_ext_drive_pullup && o_power_channel_outputs == '0;
    endproperty
    a_gnd_loss: assert property (p_gnd_loss) else $error("gnd loss wrong"); // [RULE11]

    property p_por_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        por_clear |=> fault_ff == '0 && !spi_failure_flag_ff && mode_ff == slfm_pkg::SLFM_POWER_OFF;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("power off not cleared"); // [RULE5]

    property p_no_wake_bat;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_supply.bat_ok |=> o_clk_pin_oe_n;
    endproperty
    a_no_wake_bat: assert property (p_no_wake_bat) else $error("wake shown at bat loss"); // [RULE8]

    property p_wake_drive;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !o_clk_pin_oe_n |-> o_clk_pin_out && !$past(i_reset_input_low_n) && $past(i_wake);
    endproperty
    a_wake_drive: assert property (p_wake_drive) else $error("pin driven low"); // [RULE2]

    property p_vcc_fail;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_supply.vcc_ok && i_supply.bat_ok && i_wake) |=> mode_ff == slfm_pkg::SLFM_FAIL;
    endproperty
    a_vcc_fail: assert property (p_vcc_fail) else $error("vcc loss not fail"); // [RULE9]

    property p_readback;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_supply.vcc_ok |=> !o_readback_en;
    endproperty
    a_readback: assert property (p_readback) else $error("readback without vcc"); // [RULE10]

    property p_direct;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (nxt_mode == slfm_pkg::SLFM_FAIL && i_supply.bat_ok && i_supply.gnd_ok)
        |=> o_power_channel_outputs == NUM_CH'($past(in_dgl_ff));
    endproperty
    a_direct: assert property (p_direct) else $error("fail outputs wrong"); // [RULE15]

    property p_stat7;
        @(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_stat7[`SLFM_STAT7_LIMP_BIT] == $past(i_fail_req);
    endproperty
    a_stat7: assert property (p_stat7) else $error("status bit wrong"); // [RULE17]
endmodule

// *** slfm_ctrl_tb_top.sv ***
// self-checking bench for the supply-loss and fail-mode controller
// assumes slfm_pkg and slfm_ctrl compiled first; short deglitch count
`timescale 1ns/1ps
module slfm_ctrl_tb_top;
    localparam int DGL = 8; // shortened deglitch so the run stays brief
    logic                   i_mclk, i_rst_n, i_wake, i_woken_by_reset;
    slfm_pkg::slfm_supply_t i_supply;
    slfm_pkg::slfm_spi_err_t i_spi_err;
    logic [4:0]             i_pwm_ch, o_power_channel_outputs;
    logic [7:0]             i_fault_evt, o_fault_flags, o_stat7;
    logic [3:0]             din_cmd, i_direct_channel_inputs;
    logic                   i_spi_ext_cfg, i_fault_clr, limp_cmd, rst_cmd;
    logic                   i_fail_req, i_reset_input_low_n, i_clk_pin_in;
    logic                   o_clk_pin_out, o_clk_pin_oe_n, o_clk_pin_sample;
    logic                   o_external_switch_drive, o_ext_drive_pullup, o_readback_en;
    slfm_pkg::slfm_mode_t   o_mode;
    int                     n_errors, n_checks;
    slfm_ctrl #(.NUM_CH(5), .NUM_IN(4), .DGL_CYC(DGL)) slfm_ctrl_inst (.*);
    slfm_mcu_model slfm_mcu_model_inst (.i_mclk(i_mclk), .i_limp_cmd(limp_cmd),
        .i_din_cmd(din_cmd), .i_rst_cmd(rst_cmd), .i_dev_clk_out(o_clk_pin_out),
        .i_dev_clk_oe_n(o_clk_pin_oe_n), .o_fail_req(i_fail_req),
        .o_direct_channel_inputs(i_direct_channel_inputs),
        .o_reset_input_low_n(i_reset_input_low_n), .o_clk_pin(i_clk_pin_in));
    // 25 MHz clock
    initial
    begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // one compare task per kind of result
    task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_mode(input slfm_pkg::slfm_mode_t e);
        n_checks++;
        if (o_mode !== e)
        begin
            n_errors++;
            $display("BAD mode exp %0d got %0d", e, o_mode);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // plain running state, channels from the pwm engine
    task automatic t_normal();
        i_supply = 3'b111; i_wake = 1'b1; i_pwm_ch = 5'h15; i_spi_ext_cfg = 1'b1;
        step(3);
        chk_mode(slfm_pkg::SLFM_NORMAL);
        chk_vec("chan", 8'h15, 8'(o_power_channel_outputs));
        chk_vec("ext", 8'h01, 8'(o_external_switch_drive));
    endtask
    // wake report on the clock pin while the reset pin is low
    task automatic t_wake();
        rst_cmd = 1'b0; step(3);
        chk_vec("clk_oe_n", 8'h00, 8'(o_clk_pin_oe_n));
        chk_vec("clk_pin", 8'h01, 8'(i_clk_pin_in));
        chk_vec("clk_smp", 8'h00, 8'(o_clk_pin_sample));
        i_woken_by_reset = 1'b1; step(3);
        chk_vec("clk_oe_n", 8'h01, 8'(o_clk_pin_oe_n));
        i_woken_by_reset = 1'b0; i_wake = 1'b0; step(3);
        chk_vec("clk_oe_n", 8'h01, 8'(o_clk_pin_oe_n));
        chk_mode(slfm_pkg::SLFM_SLEEP);
        chk_vec("chan", 8'h00, 8'(o_power_channel_outputs));
        i_wake = 1'b1; rst_cmd = 1'b1; step(3);
    endtask
    // sticky records for every fault class, then clear and refill
    task automatic t_faults();
        logic [7:0] acc;
        acc = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            i_fault_evt = 8'h01 << k; step(1); i_fault_evt = 8'h00; step(2);
            acc = acc | (8'h01 << k);
            chk_vec("faults", acc, o_fault_flags);
        end
        i_fault_clr = 1'b1; step(1); i_fault_clr = 1'b0; step(2);
        chk_vec("faults", 8'h00, o_fault_flags);
        i_fault_evt = 8'hFF; i_fault_clr = 1'b1; step(1);
        i_fault_evt = 8'h00; i_fault_clr = 1'b0; step(2);
        chk_vec("faults", 8'hFF, o_fault_flags);
    endtask
    // battery gone, logic supply kept; then both gone
    task automatic t_supply();
        rst_cmd = 1'b0; i_supply = 3'b011; step(3);
        chk_vec("chan", 8'h00, 8'(o_power_channel_outputs));
        chk_vec("faults", 8'hFF, o_fault_flags);
        chk_vec("clk_oe_n", 8'h01, 8'(o_clk_pin_oe_n));
        i_spi_ext_cfg = 1'b0; step(2);
        chk_vec("ext", 8'h00, 8'(o_external_switch_drive));
        i_spi_ext_cfg = 1'b1; step(2);
        chk_vec("ext", 8'h01, 8'(o_external_switch_drive));
        rst_cmd = 1'b1; i_supply = 3'b001; step(3);
        chk_mode(slfm_pkg::SLFM_POWER_OFF);
        chk_vec("outs", 8'h00, 8'({o_external_switch_drive, o_power_channel_outputs}));
        chk_vec("faults", 8'h00, o_fault_flags);
        i_supply = 3'b101; step(3);
        chk_mode(slfm_pkg::SLFM_FAIL);
        chk_vec("rdback", 8'h00, 8'(o_readback_en));
        chk_vec("spi_failure_flag", 8'h01, 8'(o_stat7[1]));
        i_supply = 3'b111; step(3);
        chk_vec("rdback", 8'h01, 8'(o_readback_en));
        chk_vec("spi_failure_flag", 8'h00, 8'(o_stat7[1]));
        i_supply = 3'b110; step(3);
        chk_vec("chan", 8'h00, 8'(o_power_channel_outputs));
        chk_vec("pullup", 8'h01, 8'(o_ext_drive_pullup));
        i_supply = 3'b111; step(3);
    endtask
    // each serial fault cause forces fail mode, removal returns to normal
    task automatic t_spi();
        for (int k = 0; k < 3; k++)
        begin
            i_spi_err = 3'b001 << k; step(3);
            chk_mode(slfm_pkg::SLFM_FAIL);
            i_spi_err = 3'b000; step(3);
            chk_mode(slfm_pkg::SLFM_NORMAL);
        end
    endtask
    // fail request: short glitch ignored, held level takes over
    task automatic t_limp();
        din_cmd = 4'hA; limp_cmd = 1'b1; step(3); limp_cmd = 1'b0; step(DGL + 4);
        chk_mode(slfm_pkg::SLFM_NORMAL);
        chk_vec("chan", 8'h15, 8'(o_power_channel_outputs));
        limp_cmd = 1'b1; step(2);
        chk_vec("limp_in", 8'h01, 8'(o_stat7[0]));
        step(DGL + 4);
        chk_mode(slfm_pkg::SLFM_FAIL);
        chk_vec("chan", 8'h0A, 8'(o_power_channel_outputs));
        din_cmd = 4'h5; step(DGL + 4);
        chk_vec("chan", 8'h05, 8'(o_power_channel_outputs));
        limp_cmd = 1'b0; step(DGL + 4);
        chk_mode(slfm_pkg::SLFM_NORMAL);
        chk_vec("limp_in", 8'h00, 8'(o_stat7[0]));
    endtask
    // hang guard, far beyond the roughly 150 cycles expected
    initial
    begin
        step(5000);
        n_errors++;
        results();
    end
    initial
    begin
        n_errors = 0; n_checks = 0; i_rst_n = 1'b0; i_wake = 1'b1;
        i_woken_by_reset = 1'b0; i_supply = 3'b111; i_spi_err = 3'b000;
        i_pwm_ch = 5'h00; i_spi_ext_cfg = 1'b0; i_fault_evt = 8'h00;
        i_fault_clr = 1'b0; limp_cmd = 1'b0; din_cmd = 4'h0; rst_cmd = 1'b1;
        step(16);
        chk_mode(slfm_pkg::SLFM_POWER_OFF);
        chk_vec("clk_oe_n", 8'h01, 8'(o_clk_pin_oe_n));
        i_rst_n = 1'b1;
        t_normal();
        t_wake();
        t_faults();
        t_supply();
        t_spi();
        t_limp();
        results();
    end
endmodule

// *** slfm_mcu_model.sv ***
// controller-side model: fail request, direct inputs, reset pin, clock pin
// assumes the bench sets the commands at the falling clock edge
`timescale 1ns/1ps
module slfm_mcu_model (
    input  wire logic       i_mclk,
    input  wire logic       i_limp_cmd,     // 1 = drive request high, 0 = release
    input  wire logic [3:0] i_din_cmd,      // 1 = drive input high, 0 = release
    input  wire logic       i_rst_cmd,      // reset pin level wanted
    input  wire logic       i_dev_clk_out,  // device clock pin driver
    input  wire logic       i_dev_clk_oe_n, // low while the device drives
    output logic            o_fail_req,
    output logic [3:0]      o_direct_channel_inputs,
    output logic            o_reset_input_low_n,
    output logic            o_clk_pin
);
    logic float_ff; // undriven line wanders each cycle
    // released pins fall to their pull-down level
    assign o_fail_req = i_limp_cmd ? 1'b1 : 1'b0;
    assign o_direct_channel_inputs = i_din_cmd;
    assign o_reset_input_low_n = i_rst_cmd;
    // floating pattern so a stale level is never mistaken for a drive
    always_ff @(posedge i_mclk)
    begin
        float_ff <= (float_ff === 1'b1) ? 1'b0 : 1'b1;
    end
    // pin level: device drive, idle serial clock, or nobody while reset low
    assign o_clk_pin = !i_dev_clk_oe_n ? i_dev_clk_out
                     : (i_rst_cmd ? 1'b0 : float_ff);
endmodule

// *** slfm_params.svh ***
// constants for the supply-loss and fail-mode controller
// assumes a single 25 MHz clock; included by bare name
`ifndef SLFM_PARAMS_SVH
`define SLFM_PARAMS_SVH
`define SLFM_CLK_MHZ         25
`define SLFM_DGL_US          200
`define SLFM_DGL_CYC         ((`SLFM_DGL_US * `SLFM_CLK_MHZ))
`define SLFM_NUM_CH          5
`define SLFM_NUM_IN          4
`define SLFM_STAT7_LIMP_BIT  0
`define SLFM_STAT7_SPI_FAILURE_FLAG_BIT  1
`define SLFM_FAULT_W         8
`define SLFM_CNT_W           13
`endif

// *** slfm_pkg.sv ***
// types for the supply-loss and fail-mode controller
// assumes slfm_params.svh is compiled alongside
package slfm_pkg;
    // operating modes of the device core
    typedef enum logic [1:0] {
        SLFM_POWER_OFF,
        SLFM_SLEEP,
        SLFM_NORMAL,
        SLFM_FAIL
    } slfm_mode_t;
    // supply and ground presence, one bit each
    typedef struct packed {
        logic bat_ok;
        logic vcc_ok;
        logic gnd_ok;
    } slfm_supply_t;
    // spi communication fault causes
    typedef struct packed {
        logic wd_toggle_err;
        logic wd_timeout;
        logic len_err;
    } slfm_spi_err_t;
endpackage
